// File: core/stp_pkg.sv
// Shared constants and code tables for the transmit coding path
package stp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int LANES_DEF = 4;
  localparam int FIFO_DEPTH = 4;
  localparam int CHAR_W = 8;
  localparam int ENTRY_W = 11;

  // Entry layout: control flag, force enable, force value, byte
  localparam int F_CTRL = 10;
  localparam int F_FE = 9;
  localparam int F_FV = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Symbol timing, one serial bit per clock
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h9;

  // Reset values
  localparam logic RD_RESET = 1'h0;
  localparam logic WORD_REQ_RESET = 1'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Code tables, 1 in rd means positive disparity
  localparam logic [7:0] IDLE_CHAR = 8'hbc;
  localparam logic [4:0] K28_IDX = 5'h1c;
  localparam logic [2:0] Y7_IDX = 3'h7;
  localparam logic [31:0] K_X7_SET = 32'h68800000;
  localparam logic [5:0] K28_6B = 6'h0f;
  localparam logic [5:0] D7_6B = 6'h38;
  localparam logic [3:0] A7_4B = 4'h7;
  localparam logic [3:0] D3_4B = 4'hc;

  // Six-bit codes for negative disparity, abcdei with a leftmost
  localparam logic [0:31][5:0] TBL_6B = {
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};

  // Four-bit codes fghj for negative disparity, data then K28 rows
  localparam logic [0:7][3:0] TBL_4B = {
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  localparam logic [0:7][3:0] TBL_4B_K28 = {
    4'hb, 4'h6, 4'ha, 4'hc, 4'hd, 4'h5, 4'h9, 4'h7};

endpackage

// File: core/stp_tx_if.sv
// Fabric-to-transceiver transmit word interface
`timescale 1ns/10ps
interface stp_tx_if #(
  parameter int LANES = 4
);
  logic word_req;
  logic word_vld;
  logic [8*LANES-1:0] tx_parallel_char_bits;
  logic [LANES-1:0] tx_char_is_control;
  logic [LANES-1:0] tx_disparity_force_enable;
  logic [LANES-1:0] tx_disparity_force_value;
  logic fifo_bypass;
  logic enc_bypass;
  logic tx_running_disparity_out;
  logic [LANES-1:0] tx_invalid_control_code_error;
  logic fifo_overflow;
  logic fifo_underflow;

  modport dev (
    input word_vld, tx_parallel_char_bits, tx_char_is_control,
    input tx_disparity_force_enable, tx_disparity_force_value,
    input fifo_bypass, enc_bypass,
    output word_req, tx_running_disparity_out, tx_invalid_control_code_error,
    output fifo_overflow, fifo_underflow
  );

  modport fab (
    output word_vld, tx_parallel_char_bits, tx_char_is_control,
    output tx_disparity_force_enable, tx_disparity_force_value,
    output fifo_bypass, enc_bypass,
    input word_req, tx_running_disparity_out, tx_invalid_control_code_error,
    input fifo_overflow, fifo_underflow
  );
endinterface

// File: core/stp_enc.sv
// Combinational 8b/10b character encoder with control-code check
`timescale 1ns/10ps
module stp_enc (
  // Character in
  input wire logic [7:0] byte_i,
  input wire logic k_i,
  input wire logic rd_i,
  // Code out
  output logic [9:0] sym_o,
  output logic rd_o,
  output logic kerr_o
);

  logic k28;
  logic kval;
  logic u6;
  logic u4;
  logic rd6;
  logic [5:0] c6;
  logic [3:0] t4;
  logic [2:0] y;

  always_comb
  begin
    y = byte_i[7:5];
    k28 = k_i && (byte_i[4:0] == stp_pkg::K28_IDX);
    kval = k28 || ((y == stp_pkg::Y7_IDX) && stp_pkg::K_X7_SET[byte_i[4:0]]);
    kerr_o = k_i && !kval; // [RQ17]
    // Invalid control bytes still go out as data so the line keeps running
    c6 = k28 ? stp_pkg::K28_6B : stp_pkg::TBL_6B[byte_i[4:0]]; // [RQ15] [RQ16]
    u6 = ($countones(c6) != 3);
    rd6 = rd_i ^ u6;
    if (rd_i && (u6 || (c6 == stp_pkg::D7_6B)))
    begin
      c6 = ~c6;
    end
    t4 = k28 ? stp_pkg::TBL_4B_K28[y] : stp_pkg::TBL_4B[y];
    // Alternate y7 avoids a run of five equal bits across the boundary
    if ((y == stp_pkg::Y7_IDX) && !k28 && ((k_i && kval) ||
        (!rd6 && c6[1] && c6[0]) || (rd6 && !c6[1] && !c6[0])))
    begin
      t4 = stp_pkg::A7_4B; // [RQ16]
    end
    u4 = ($countones(t4) != 2);
    if (rd6 && (u4 || (t4 == stp_pkg::D3_4B) || k28))
    begin
      t4 = ~t4;
    end
    sym_o = {c6, t4};
    rd_o = rd6 ^ u4;
  end

endmodule

// File: core/stp_tx_pcs.sv
// Device end: word intake, four-entry FIFO, encoder and serializer
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Contract
// [RQ1] Fabric clocks ratio follows fabric word width
// [RQ2] Slower clock edges meet faster falling edges
// [RQ3] One, two or four characters, 8 or 10 bits
// [RQ4] In 8-bit mode extra bits steer encoder
// [RQ5] Raw order: force enable, force value, bits 7..0
// [RQ6] Lowest byte of a word goes out first
// [RQ7] Running disparity starts negative
// [RQ8] Running disparity always visible to fabric
// [RQ9] Per-character force bits set disparity before byte
// [RQ10] Fabric clock frequency-locked, one cycle wander
// [RQ11] Transmit FIFO holds four entries
// [RQ12] FIFO overflow and underflow reported to fabric
// [RQ13] FIFO can be bypassed
// [RQ14] Encoder can be bypassed for raw characters
// [RQ15] Eight bits plus control flag give ten
// [RQ16] Control flag selects control or data code
// [RQ17] Unknown control byte raises invalid-code error
// [RQ18] Invalid-code error per lane, aligned to word
module stp_tx_pcs #(
  parameter int LANES = stp_pkg::LANES_DEF,
  parameter int DEPTH = stp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Fabric side
  stp_tx_if.dev fab,
  // Serializer side
  output logic ser_bit_o,
  output logic sym_start_o,
  output logic [9:0] tx_sym_o
);

  localparam int EW = stp_pkg::ENTRY_W;
  localparam int WW = EW * LANES;
  localparam int LBW = (LANES > 1) ? $clog2(LANES) : 1;
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [LBW-1:0] LANE_LAST = LBW'(LANES - 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);

  logic [3:0] bit_ff;
  logic [LBW-1:0] lane_ff;
  logic char_start, word_end, fifo_empty, fifo_full, push, pop;
  logic [WW-1:0] in_word, byp_ff, word_ff;
  logic [WW-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff, rd_ptr_ff;
  logic [PW:0] cnt_ff;
  logic byp_vld_ff, word_vld_ff, idle, raw, k, fe, fv;
  logic [EW-1:0] entry;
  logic [7:0] byte_sel;
  logic enc_rd_in, enc_rd_out, enc_kerr, rd_ff;
  logic [9:0] enc_sym, sh_ff, sym_ff;
  logic [LANES-1:0] kacc_ff, kerr_ff;
  logic ovf_ff, unf_ff, word_req_ff, sym_start_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Symbol and lane cadence; one word per LANES symbols keeps the rate locked
  assign char_start = (bit_ff == stp_pkg::BIT_FIRST);
  assign word_end = (bit_ff == stp_pkg::BIT_LAST) && (lane_ff == LANE_LAST);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      bit_ff <= stp_pkg::BIT_FIRST;
      lane_ff <= '0;
    end
    else if (bit_ff == stp_pkg::BIT_LAST)
    begin
      bit_ff <= stp_pkg::BIT_FIRST;
      lane_ff <= (lane_ff == LANE_LAST) ? '0 : lane_ff + 1'b1; // [RQ6]
    end
    else
    begin
      bit_ff <= bit_ff + 4'h1;
    end
  end

  // Request marks the first cycle of every word period
  always_ff @(posedge clk_i)
  begin
    word_req_ff <= rst_n_i ? word_end : stp_pkg::WORD_REQ_RESET; // [RQ10]
  end

  assign fab.word_req = word_req_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Word packing, lane 0 in the low bits
  always_comb
  begin
    in_word = '0;
    for (int l = 0; l < LANES; l++)
    begin
      in_word[l*EW +: EW] = {fab.tx_char_is_control[l], fab.tx_disparity_force_enable[l],
                             fab.tx_disparity_force_value[l],
                             fab.tx_parallel_char_bits[l*stp_pkg::CHAR_W +: stp_pkg::CHAR_W]}; // [RQ3]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO; no fall-through, so a word written in the pop cycle waits
  assign fifo_empty = (cnt_ff == '0);
  assign fifo_full = (cnt_ff == FULL_CNT);
  assign push = fab.word_vld && !fab.fifo_bypass && (!fifo_full || word_end);
  assign pop = word_end && !fab.fifo_bypass && !fifo_empty;

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_word; // [RQ11]
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || fab.fifo_bypass)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= (wr_ptr_ff == PTR_LAST) ? '0 : wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= (rd_ptr_ff == PTR_LAST) ? '0 : rd_ptr_ff + 1'b1;
      case ({push, pop})
        2'b10: cnt_ff <= cnt_ff + 1'b1;
        2'b01: cnt_ff <= cnt_ff - 1'b1;
        default: cnt_ff <= cnt_ff;
      endcase
    end
  end

  // Bypass keeps a single word; a new word in the take cycle still lands
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      byp_ff <= '0;
      byp_vld_ff <= 1'b0;
    end
    else if (fab.word_vld && fab.fifo_bypass)
    begin
      byp_ff <= in_word; // [RQ13]
      byp_vld_ff <= 1'b1;
    end
    else if (word_end)
    begin
      byp_vld_ff <= 1'b0;
    end
  end

  // Overflow and underflow, one-cycle pulses
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ovf_ff <= 1'b0;
      unf_ff <= 1'b0;
    end
    else
    begin
      ovf_ff <= fab.word_vld && !word_end && (fab.fifo_bypass ? byp_vld_ff : fifo_full); // [RQ12]
      unf_ff <= word_end && (fab.fifo_bypass ? !byp_vld_ff : fifo_empty); // [RQ12]
    end
  end

  assign fab.fifo_overflow = ovf_ff;
  assign fab.fifo_underflow = unf_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Current word; a missing word is filled with idle commas
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      word_ff <= '0;
      word_vld_ff <= 1'b0;
    end
    else if (word_end)
    begin
      word_ff <= fab.fifo_bypass ? byp_ff : mem_ff[rd_ptr_ff];
      word_vld_ff <= fab.fifo_bypass ? byp_vld_ff : !fifo_empty;
    end
  end

  always_comb
  begin
    entry = word_ff[lane_ff*EW +: EW]; // [RQ6]
    idle = !word_vld_ff;
    byte_sel = idle ? stp_pkg::IDLE_CHAR : entry[stp_pkg::CHAR_W-1:0];
    k = idle || entry[stp_pkg::F_CTRL];
    fe = !idle && entry[stp_pkg::F_FE];
    fv = entry[stp_pkg::F_FV];
    raw = fab.enc_bypass && !idle; // [RQ14]
    enc_rd_in = fe ? fv : rd_ff; // [RQ4] [RQ9]
  end

  stp_enc u_enc (
    .byte_i(byte_sel),
    .k_i(k),
    .rd_i(enc_rd_in),
    .sym_o(enc_sym),
    .rd_o(enc_rd_out),
    .kerr_o(enc_kerr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Serializer, bit 9 first
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sh_ff <= '0;
      sym_ff <= '0;
      sym_start_ff <= 1'b0;
    end
    else
    begin
      sym_start_ff <= char_start;
      if (char_start)
      begin
        sh_ff <= raw ? {fe, fv, byte_sel} : enc_sym; // [RQ5] [RQ15]
        sym_ff <= raw ? {fe, fv, byte_sel} : enc_sym;
      end
      else
        sh_ff <= {sh_ff[8:0], 1'b0};
    end
  end

  assign ser_bit_o = sh_ff[9];
  assign sym_start_o = sym_start_ff;
  assign tx_sym_o = sym_ff;

  // Raw characters carry no known disparity, so the tracker holds
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rd_ff <= stp_pkg::RD_RESET; // [RQ7]
    else if (char_start && !raw)
      rd_ff <= enc_rd_out; // [RQ9]
  end

  assign fab.tx_running_disparity_out = rd_ff; // [RQ8]

  ////////////////////////////////////////////////////////////////////////////
  // Invalid control codes, gathered per lane and published per word
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      kacc_ff <= '0;
      kerr_ff <= '0;
    end
    else
    begin
      if (char_start)
        kacc_ff[lane_ff] <= enc_kerr && !raw && !idle; // [RQ17]
      if (word_end)
        kerr_ff <= kacc_ff; // [RQ18]
    end
  end

  assign fab.tx_invalid_control_code_error = kerr_ff;

endmodule

// File: core/stp_fab_src.sv
// Fabric end: holds one user word and hands it over on the next word request
`timescale 1ns/10ps
module stp_fab_src #(
  parameter int LANES = stp_pkg::LANES_DEF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Transceiver side
  stp_tx_if.fab dev,
  // User word
  input wire logic usr_vld_i,
  input wire logic [8*LANES-1:0] usr_chars_i,
  input wire logic [LANES-1:0] usr_ctrl_i,
  input wire logic [LANES-1:0] usr_force_en_i,
  input wire logic [LANES-1:0] usr_force_val_i,
  output logic usr_rdy_o,
  // Configuration
  input wire logic cfg_fifo_bypass_i,
  input wire logic cfg_enc_bypass_i,
  // Status
  input wire logic usr_status_clr_i,
  output logic usr_run_disp_o,
  output logic [LANES-1:0] usr_kerr_o,
  output logic usr_ovf_o,
  output logic usr_unf_o
);

  localparam int WW = stp_pkg::ENTRY_W * LANES;

  logic [WW-1:0] pend_ff;
  logic pend_vld_ff;
  logic rdy_ff;
  logic accept;
  logic send;
  logic nxt_pend_vld;
  logic vld_ff;
  logic [WW-1:0] out_ff;
  logic fifo_byp_ff;
  logic enc_byp_ff;
  logic rd_ff;
  logic [LANES-1:0] kerr_ff;
  logic ovf_ff;
  logic unf_ff;

  ////////////////////////////////////////////////////////////////////////////
  // One word per request keeps the word rate locked to the symbol rate
  assign accept = usr_vld_i && rdy_ff;
  assign send = dev.word_req && pend_vld_ff; // [RQ1] [RQ2] [RQ10]
  assign nxt_pend_vld = (pend_vld_ff && !send) || accept;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pend_ff <= '0;
      pend_vld_ff <= 1'b0;
      rdy_ff <= 1'b0;
    end
    else
    begin
      if (accept)
      begin
        pend_ff <= {usr_ctrl_i, usr_force_en_i, usr_force_val_i, usr_chars_i};
      end
      pend_vld_ff <= nxt_pend_vld;
      rdy_ff <= !nxt_pend_vld;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      vld_ff <= 1'b0;
      out_ff <= '0;
      fifo_byp_ff <= 1'b0;
      enc_byp_ff <= 1'b0;
    end
    else
    begin
      vld_ff <= send;
      if (send)
      begin
        out_ff <= pend_ff; // [RQ9]
      end
      fifo_byp_ff <= cfg_fifo_bypass_i;
      enc_byp_ff <= cfg_enc_bypass_i;
    end
  end

  assign usr_rdy_o = rdy_ff;
  assign dev.word_vld = vld_ff;
  assign {dev.tx_char_is_control, dev.tx_disparity_force_enable,
          dev.tx_disparity_force_value, dev.tx_parallel_char_bits} = out_ff;
  assign dev.fifo_bypass = fifo_byp_ff;
  assign dev.enc_bypass = enc_byp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Status; overflow and underflow flags sticky, a new event beats a clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_ff <= 1'b0;
      kerr_ff <= '0;
      ovf_ff <= 1'b0;
      unf_ff <= 1'b0;
    end
    else
    begin
      rd_ff <= dev.tx_running_disparity_out;
      kerr_ff <= dev.tx_invalid_control_code_error;
      ovf_ff <= dev.fifo_overflow || (ovf_ff && !usr_status_clr_i);
      unf_ff <= dev.fifo_underflow || (unf_ff && !usr_status_clr_i);
    end
  end

  assign usr_run_disp_o = rd_ff;
  assign usr_kerr_o = kerr_ff;
  assign usr_ovf_o = ovf_ff;
  assign usr_unf_o = unf_ff;

endmodule

// File: verification/stp_tb_asserts.sv
// Checker on the transmit word interface between fabric and device ends
`timescale 1ns/10ps
module stp_tb_asserts #(
  parameter int LANES = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Interface signals
  input wire logic word_req,
  input wire logic word_vld,
  input wire logic tx_running_disparity_out,
  input wire logic [LANES-1:0] tx_invalid_control_code_error,
  input wire logic fifo_overflow,
  input wire logic fifo_underflow
);
  // One word period is LANES symbols of ten bits
  localparam int PER = 10 * LANES;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  ////////////////////////////////////////////////////////////////////////////
  chk_req_cadence: assert property (word_req |-> ##PER word_req)
    else $error("word request cadence broken");
  chk_req_gap: assert property (word_req |=> !word_req [*8])
    else $error("word request repeated too soon");
  chk_req_release: assert property ($rose(rst_n_i) |-> word_req)
    else $error("no word request at reset release");
  chk_rd_start: assert property ($rose(rst_n_i) |-> !tx_running_disparity_out)
    else $error("running disparity not negative after reset");
  chk_vld_after_req: assert property (word_vld |-> $past(word_req))
    else $error("word offered without a request");
  chk_vld_single: assert property (word_vld |=> !word_vld [*8])
    else $error("more than one word in a period");
  chk_rd_hold: assert property ($changed(tx_running_disparity_out) |=>
    $stable(tx_running_disparity_out) [*8])
    else $error("running disparity changed within a symbol");
  chk_kerr_hold: assert property ($changed(tx_invalid_control_code_error) |=>
    $stable(tx_invalid_control_code_error) [*8])
    else $error("lane error not held for a word period");
  chk_unf_pulse: assert property (fifo_underflow |=> !fifo_underflow [*8])
    else $error("underflow pulse too long");
  chk_ovf_cause: assert property (fifo_overflow |-> $past(word_vld))
    else $error("overflow without a write");

  ////////////////////////////////////////////////////////////////////////////
  cov_word: cover property (word_vld);
  cov_kerr: cover property (|tx_invalid_control_code_error);
  cov_unf: cover property (fifo_underflow);
  cov_rd: cover property ($rose(tx_running_disparity_out));
endmodule

// File: verification/tb.sv
// Testbench joining fabric end and device end of the transmit path
`timescale 1ns/10ps
module tb;
  localparam int LANES = 2;
  logic clk_i;
  logic rst_n_i;
  logic usr_vld;
  logic [15:0] usr_chars;
  logic [1:0] usr_ctrl;
  logic [1:0] usr_fe;
  logic [1:0] usr_fv;
  logic usr_rdy;
  logic cfg_fifo_byp;
  logic cfg_enc_byp;
  logic run_disp;
  logic [1:0] kerr;
  logic ser_bit;
  logic sym_start;
  logic [9:0] sh;
  logic [9:0] tx_sym;
  logic [9:0] tx_sym_prev;
  logic unf;
  logic ovf;
  logic status_clr;
  logic started;
  logic [9:0] syms[$];
  int failures;
  int samples_checked;
  int n;

  stp_tx_if #(.LANES(LANES)) bus ();
  stp_tx_pcs #(.LANES(LANES), .DEPTH(stp_pkg::FIFO_DEPTH)) i_stp_tx_pcs (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .fab(bus),
    .ser_bit_o(ser_bit), .sym_start_o(sym_start), .tx_sym_o(tx_sym));
  stp_fab_src #(.LANES(LANES)) i_stp_fab_src (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .dev(bus),
    .usr_vld_i(usr_vld), .usr_chars_i(usr_chars), .usr_ctrl_i(usr_ctrl),
    .usr_force_en_i(usr_fe), .usr_force_val_i(usr_fv), .usr_rdy_o(usr_rdy),
    .cfg_fifo_bypass_i(cfg_fifo_byp), .cfg_enc_bypass_i(cfg_enc_byp),
    .usr_status_clr_i(status_clr), .usr_run_disp_o(run_disp), .usr_kerr_o(kerr),
    .usr_ovf_o(ovf), .usr_unf_o(unf));
  stp_tb_asserts #(.LANES(LANES)) i_stp_tb_asserts (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .word_req(bus.word_req), .word_vld(bus.word_vld),
    .tx_running_disparity_out(bus.tx_running_disparity_out),
    .tx_invalid_control_code_error(bus.tx_invalid_control_code_error),
    .fifo_overflow(bus.fifo_overflow), .fifo_underflow(bus.fifo_underflow));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rebuild symbols from the line, so bit order is judged on the wire
  // Sampled mid-cycle, away from the edge that launches the line bits
  always @(negedge clk_i)
  begin
    if (!rst_n_i)
      started = 1'b0;
    else if (sym_start === 1'b1)
    begin
      if (started)
      begin
        syms.push_back(sh);
        cmp_sym("parallel symbol", tx_sym_prev, sh);
      end
      started = 1'b1;
      tx_sym_prev = tx_sym;
    end
    sh = {sh[8:0], ser_bit};
  end

  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task timeout;
    failures++;
    $display("[FAIL] wait expected done seen timeout");
    end_sim();
  endtask

  task cmp_sym(input string what, input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task cmp_flag(input string what, input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  // One word in, first two non-idle symbols compared
  task run(input logic [15:0] ch, input logic [1:0] k, input logic [1:0] fe,
           input logic [1:0] fv, input logic [9:0] e0, input logic [9:0] e1);
    int c;
    int i;
    c = 0;
    i = 0;
    syms.delete();
    @(negedge clk_i);
    while (usr_rdy !== 1'b1 && c < 100)
    begin
      @(negedge clk_i);
      c++;
    end
    if (c == 100)
      timeout();
    usr_vld = 1'b1;
    usr_chars = ch;
    usr_ctrl = k;
    usr_fe = fe;
    usr_fv = fv;
    @(negedge clk_i);
    usr_vld = 1'b0;
    c = 0;
    while (c < 400)
    begin
      @(negedge clk_i);
      i = 0;
      while (i < syms.size() && (syms[i] === 10'h0fa || syms[i] === 10'h305))
        i++;
      if (i + 1 < syms.size())
        break;
      c++;
    end
    if (c == 400)
      timeout();
    cmp_sym("lane0 symbol", syms[i], e0);
    cmp_sym("lane1 symbol", syms[i+1], e1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n_i = 1'b0;
    usr_vld = 1'b0;
    usr_chars = 16'h0000;
    usr_ctrl = 2'h0;
    usr_fe = 2'h0;
    usr_fv = 2'h0;
    cfg_fifo_byp = 1'b0;
    cfg_enc_byp = 1'b0;
    status_clr = 1'b0;
    failures = 0;
    samples_checked = 0;
    repeat (6) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    cmp_flag("run disparity", {1'b0, run_disp}, 2'b00);
    n = 0;
    while (syms.size() < 2 && n < 200)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n == 200)
      timeout();
    cmp_sym("idle first", syms[0], 10'h0fa);
    cmp_sym("idle second", syms[1], 10'h305);
    cmp_flag("underflow", {1'b0, unf}, 2'b01);
    cfg_enc_byp = 1'b1;
    run(16'hc35a, 2'b00, 2'b01, 2'b10, 10'h25a, 10'h1c3);
    cfg_enc_byp = 1'b0;
    cfg_fifo_byp = 1'b1;
    run(16'h1c1c, 2'b11, 2'b11, 2'b01, 10'h30b, 10'h0f4);
    cfg_fifo_byp = 1'b0;
    run(16'h0000, 2'b10, 2'b01, 2'b00, 10'h274, 10'h274);
    n = 0;
    while (kerr === 2'b00 && n < 200)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n == 200)
      timeout();
    cmp_flag("lane error", kerr, 2'b10);
    cmp_flag("overflow", {1'b0, ovf}, 2'b00);
    status_clr = 1'b1;
    @(negedge clk_i);
    status_clr = 1'b0;
    cmp_flag("underflow cleared", {1'b0, unf}, 2'b00);
    end_sim();
  end
endmodule
